// [wtc_pkg.sv]
`default_nettype none
package wtc_pkg;
  // percent quantities carry 0.01 % per lsb, so unity is 100.00 %
  localparam int PCT_W = 16;
  typedef logic signed [PCT_W-1:0] wtc_pct_t;

  localparam logic signed [PCT_W-1:0] PCT_UNITY = 16'h2710;
  localparam logic signed [PCT_W-1:0] REEL_STILL_LIMIT = 16'h00c8;
  localparam logic [PCT_W-1:0] SCALER_UNIT = 16'h0064;

  // wishbone byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_BREAKAWAY_COMP = 8'h04;
  localparam logic [7:0] ADR_BREAKAWAY_THR = 8'h08;
  localparam logic [7:0] ADR_STATIC_FRIC = 8'h0c;
  localparam logic [7:0] ADR_DYNAMIC_FRIC = 8'h10;
  localparam logic [7:0] ADR_FIXED_MASS = 8'h14;
  localparam logic [7:0] ADR_VAR_MASS = 8'h18;
  localparam logic [7:0] ADR_MAT_WIDTH = 8'h1c;
  localparam logic [7:0] ADR_ACCEL_SCALER = 8'h20;
  localparam logic [7:0] ADR_ACCEL_PORT = 8'h24;
  localparam logic [7:0] ADR_FILTER_TC = 8'h28;
  localparam logic [7:0] ADR_PULL_SCALER = 8'h2c;
  localparam logic [7:0] ADR_MIN_DIA = 8'h30;
  localparam logic [7:0] ADR_TOTAL_MON = 8'h34;
  localparam logic [7:0] ADR_MASS_MON = 8'h38;

  // control register fields
  localparam int CTRL_TENS_EN = 0;
  localparam int CTRL_OVERWIND = 1;
  localparam int CTRL_FRIC_INV = 2;
  localparam int CTRL_W = 3;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [PCT_W-1:0] ACCEL_SCALER_RST = 16'h03e8;
  localparam logic [PCT_W-1:0] PULL_SCALER_RST = 16'h0064;
  localparam logic [PCT_W-1:0] MIN_DIA_RST = 16'h03e8;
  localparam logic [PCT_W-1:0] MAT_WIDTH_RST = 16'h2710;
  localparam logic [3:0] FILTER_TC_RST = 4'h0;

  // sample timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_NS = 1000000;
  localparam int SAMPLE_CYCLES_DOC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SAMPLES_PER_SEC = 1000000000 / SAMPLE_PERIOD_NS;
  localparam int DIV_W = 64;
  localparam int FILT_FRAC = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TENS = 3'h1,
    ST_FIX = 3'h3,
    ST_VAR = 3'h2,
    ST_SUM = 3'h6
  } wtc_state_t;

  typedef struct packed {
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } wtc_wb_req_t;

  typedef struct packed {
    wtc_pct_t lineSpeed;
    wtc_pct_t webSpeedRef;
    wtc_pct_t webSpeed;
    wtc_pct_t reelSpeedFb;
    wtc_pct_t diameter;
    wtc_pct_t pullDemand;
    wtc_pct_t memValue;
  } wtc_proc_in_t;

  typedef struct packed {
    wtc_pct_t posLimit;
    wtc_pct_t negLimit;
  } wtc_clamp_t;
endpackage : wtc_pkg
`default_nettype wire

// [wtc_winder_torque_compensator.sv]
`timescale 1ns/100ps
`default_nettype none
// Function
// [R1] dynamic friction term scales linearly with present web speed from zero
// [R2] fixed inertia weighted by min diameter over diameter, unity at minimum
// [R3] variable inertia weighted by normalised diameter cube, zero min, unity max
// [R4] both inertia gains use the diameter from the diameter calculator
// [R5] variable inertia scaled by material width factor, 100 % meaning reference
// [R6] calculated acceleration is the time derivative of line speed
// [R7] differentiated speed is multiplied by the acceleration scaler
// [R8] scaler zero selects external acceleration, else port reports calculated value
// [R9] configuring party arranges acceleration to read 100 % at maximum
// [R10] configuring party sets scaler equal to full scale ramp time in seconds
// [R11] acceleration passes a low pass filter with settable time constant
// [R12] tension term is demand times diameter divided by tension scaler
// [R13] memory select holds torque output at the memory input value
// [R14] tension disabled keeps prevailing limits, enabled uses computed demand
// [R15] overwind drives positive clamp, underwind drives negative clamp
// [R16] breakaway compensation only above speed threshold with reel below 2 %
// [R17] static friction added at constant level at any speed
// [R18] torque demand sums tension and all compensation terms, monitored
// [R19] inertia term is filtered accel times weighted inertia sum, monitored
// [R20] friction sign setting inverts the friction terms
module wtc_winder_torque_compensator
  import wtc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DOC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // wishbone slave
  input wire wtc_wb_req_t wbReq,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  // process inputs from neighbouring logic
  input wire wtc_proc_in_t procIn,
  input wire logic memSelect,
  input wire wtc_clamp_t prevailing,
  // results
  output wtc_clamp_t clampOut,
  output wtc_pct_t totalDemandMonitor,
  output wtc_pct_t massTermMonitor,
  output wtc_pct_t accelerationPort
);

  // three serial divides plus the sum must finish inside one sample
  if (SAMPLE_CYCLES < 3 * DIV_W + 8) begin : g_bad_sample
    $error("SAMPLE_CYCLES too small for the divider sequence");
  end

  function automatic wtc_pct_t sat(input logic signed [63:0] x);
    if (x > 64'sh7fff) begin
      sat = 16'h7fff;
    end else if (x < -64'sh8000) begin
      sat = 16'h8000;
    end else begin
      sat = x[15:0];
    end
  endfunction : sat

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic signed [63:0] perUnit(input logic signed [63:0] x);
    perUnit = x / 64'(PCT_UNITY);
  endfunction : perUnit

  function automatic logic [15:0] mag(input wtc_pct_t x);
    mag = x[15] ? 16'(-x) : x;
  endfunction : mag

  // configuration registers
  logic [CTRL_W-1:0] ctrl_q;
  wtc_pct_t breakawayComp_q, breakaway_speed_threshold_q, staticFric_q, dynamicFric_q;
  wtc_pct_t fixedMass_q, varMass_q, matWidth_q, accelExt_q;
  logic [15:0] accelScaler_q, pullScaler_q, minDia_q;
  logic [3:0] filterTc_q;
  logic ack_q;
  logic [31:0] rdat_q;

  logic wbHit;
  assign wbHit = wbReq.cyc && wbReq.stb && !ack_q;
  assign wbAck = ack_q;
  assign wbDatOut = rdat_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RST;
      breakawayComp_q <= '0;
      breakaway_speed_threshold_q <= '0;
      staticFric_q <= '0;
      dynamicFric_q <= '0;
      fixedMass_q <= '0;
      varMass_q <= '0;
      matWidth_q <= MAT_WIDTH_RST;
      accelScaler_q <= ACCEL_SCALER_RST;
      accelExt_q <= '0;
      filterTc_q <= FILTER_TC_RST;
      pullScaler_q <= PULL_SCALER_RST;
      minDia_q <= MIN_DIA_RST;
    end else if (clkEn && wbHit && wbReq.we) begin
      case (wbReq.adr)
        ADR_CTRL: begin
          if (wbReq.sel[0]) begin
            ctrl_q <= wbReq.dat[CTRL_W-1:0];
          end
        end
        ADR_BREAKAWAY_COMP: breakawayComp_q <= merge(breakawayComp_q, wbReq.dat, wbReq.sel);
        ADR_BREAKAWAY_THR: begin
          breakaway_speed_threshold_q <= merge(breakaway_speed_threshold_q, wbReq.dat,
                                               wbReq.sel);
        end
        ADR_STATIC_FRIC: staticFric_q <= merge(staticFric_q, wbReq.dat, wbReq.sel);
        ADR_DYNAMIC_FRIC: dynamicFric_q <= merge(dynamicFric_q, wbReq.dat, wbReq.sel);
        ADR_FIXED_MASS: fixedMass_q <= merge(fixedMass_q, wbReq.dat, wbReq.sel);
        ADR_VAR_MASS: varMass_q <= merge(varMass_q, wbReq.dat, wbReq.sel);
        ADR_MAT_WIDTH: matWidth_q <= merge(matWidth_q, wbReq.dat, wbReq.sel);
        ADR_ACCEL_SCALER: accelScaler_q <= merge(accelScaler_q, wbReq.dat, wbReq.sel);
        ADR_ACCEL_PORT: accelExt_q <= merge(accelExt_q, wbReq.dat, wbReq.sel);
        ADR_FILTER_TC: begin
          if (wbReq.sel[0]) begin
            filterTc_q <= wbReq.dat[3:0];
          end
        end
        ADR_PULL_SCALER: pullScaler_q <= merge(pullScaler_q, wbReq.dat, wbReq.sel);
        ADR_MIN_DIA: minDia_q <= merge(minDia_q, wbReq.dat, wbReq.sel);
        default: ;
      endcase
    end
  end

  // single wait state: ack follows the request edge, then drops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else if (clkEn) begin
      ack_q <= wbHit;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdat_q <= '0;
    end else if (clkEn && wbHit) begin
      case (wbReq.adr)
        ADR_CTRL: rdat_q <= {{(32-CTRL_W){1'b0}}, ctrl_q};
        ADR_BREAKAWAY_COMP: rdat_q <= {16'h0000, breakawayComp_q};
        ADR_BREAKAWAY_THR: rdat_q <= {16'h0000, breakaway_speed_threshold_q};
        ADR_STATIC_FRIC: rdat_q <= {16'h0000, staticFric_q};
        ADR_DYNAMIC_FRIC: rdat_q <= {16'h0000, dynamicFric_q};
        ADR_FIXED_MASS: rdat_q <= {16'h0000, fixedMass_q};
        ADR_VAR_MASS: rdat_q <= {16'h0000, varMass_q};
        ADR_MAT_WIDTH: rdat_q <= {16'h0000, matWidth_q};
        ADR_ACCEL_SCALER: rdat_q <= {16'h0000, accelScaler_q};
        ADR_ACCEL_PORT: rdat_q <= {16'h0000, accelerationPort};
        ADR_FILTER_TC: rdat_q <= {28'h0000000, filterTc_q};
        ADR_PULL_SCALER: rdat_q <= {16'h0000, pullScaler_q};
        ADR_MIN_DIA: rdat_q <= {16'h0000, minDia_q};
        ADR_TOTAL_MON: rdat_q <= {16'h0000, totalDemandMonitor};
        ADR_MASS_MON: rdat_q <= {16'h0000, massTermMonitor};
        default: rdat_q <= '0;
      endcase
    end
  end

  // sample tick
  logic [31:0] tickCnt_q;
  logic tick;
  assign tick = (tickCnt_q == 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tickCnt_q <= '0;
    end else if (clkEn) begin
      tickCnt_q <= tick ? '0 : tickCnt_q + 32'h1;
    end
  end

  // acceleration path
  wtc_pct_t lastSpeed_q, accelCalc_q, accelSel;
  logic signed [31:0] accelFilt_q;
  logic signed [31:0] accelTarget;
  wtc_pct_t accelF;
  logic signed [63:0] dvRaw;

  assign dvRaw = (64'(procIn.lineSpeed) - 64'(lastSpeed_q)) * 64'(SAMPLES_PER_SEC)
                 * $signed({48'h0, accelScaler_q}) / $signed({48'h0, SCALER_UNIT}); // [R6] [R7]
  assign accelSel = (accelScaler_q == '0) ? accelExt_q : accelCalc_q; // [R8]
  assign accelerationPort = accelSel;
  assign accelTarget = $signed({accelSel, 16'h0000});
  assign accelF = accelFilt_q[31:FILT_FRAC];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lastSpeed_q <= '0;
      accelCalc_q <= '0;
      accelFilt_q <= '0;
    end else if (clkEn && tick) begin
      lastSpeed_q <= procIn.lineSpeed;
      accelCalc_q <= sat(dvRaw); // [R6] [R7]
      // shift filter: time constant is 2^tc samples, cheap and never unstable
      accelFilt_q <= accelFilt_q + ((accelTarget - accelFilt_q) >>> filterTc_q); // [R11]
    end
  end

  // shared restoring divider stepped by the sequencer
  wtc_state_t state_q;
  logic [DIV_W-1:0] num_q, den_q, quo_q, rem_q;
  logic [6:0] bitCnt_q;
  logic divDone;
  logic [DIV_W-1:0] remShift;
  logic [DIV_W-1:0] quoNow;
  wtc_proc_in_t snap_q;
  logic [15:0] dia_q;
  logic tensNeg_q;
  logic signed [31:0] tensTerm_q, gainFix_q, gainVar_q;

  assign divDone = (bitCnt_q == 7'(DIV_W));
  assign remShift = {rem_q[DIV_W-2:0], num_q[DIV_W-1]};
  assign quoNow = (den_q == '0) ? '0 : quo_q;

  logic [15:0] diaClamp;
  logic [63:0] diaCube, minCube, maxCube;
  always_comb begin
    diaClamp = procIn.diameter[15] ? minDia_q : procIn.diameter; // [R4]
    if (diaClamp < minDia_q) begin
      diaClamp = minDia_q;
    end
    if (diaClamp > PCT_UNITY) begin
      diaClamp = PCT_UNITY;
    end
    if (diaClamp == '0) begin
      diaClamp = 16'h0001;
    end
    diaCube = 64'(dia_q) * 64'(dia_q) * 64'(dia_q);
    minCube = 64'(minDia_q) * 64'(minDia_q) * 64'(minDia_q);
    maxCube = 64'(PCT_UNITY) * 64'(PCT_UNITY) * 64'(PCT_UNITY);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      num_q <= '0;
      den_q <= '0;
      quo_q <= '0;
      rem_q <= '0;
      bitCnt_q <= '0;
      snap_q <= '0;
      dia_q <= '0;
      tensNeg_q <= 1'b0;
      tensTerm_q <= '0;
      gainFix_q <= '0;
      gainVar_q <= '0;
    end else if (clkEn) begin
      if (state_q != ST_IDLE && !divDone) begin
        rem_q <= (remShift >= den_q) ? remShift - den_q : remShift;
        quo_q <= {quo_q[DIV_W-2:0], remShift >= den_q};
        num_q <= {num_q[DIV_W-2:0], 1'b0};
        bitCnt_q <= bitCnt_q + 7'h1;
      end
      case (state_q)
        ST_IDLE: begin
          if (tick) begin
            snap_q <= procIn;
            dia_q <= diaClamp;
            tensNeg_q <= procIn.pullDemand[15];
            num_q <= 64'(mag(procIn.pullDemand)) * 64'(diaClamp); // [R12]
            den_q <= 64'(pullScaler_q) * 64'(SCALER_UNIT);
            quo_q <= '0;
            rem_q <= '0;
            bitCnt_q <= '0;
            state_q <= ST_TENS;
          end
        end
        ST_TENS: begin
          if (divDone) begin
            tensTerm_q <= tensNeg_q ? -32'(quoNow) : 32'(quoNow); // [R12]
            num_q <= 64'(minDia_q) * 64'(PCT_UNITY); // [R2]
            den_q <= 64'(dia_q);
            quo_q <= '0;
            rem_q <= '0;
            bitCnt_q <= '0;
            state_q <= ST_FIX;
          end
        end
        ST_FIX: begin
          if (divDone) begin
            gainFix_q <= 32'(quoNow); // [R2]
            num_q <= (diaCube - minCube) * 64'(PCT_UNITY); // [R3]
            den_q <= maxCube - minCube;
            quo_q <= '0;
            rem_q <= '0;
            bitCnt_q <= '0;
            state_q <= ST_VAR;
          end
        end
        ST_VAR: begin
          if (divDone) begin
            gainVar_q <= 32'(quoNow); // [R3]
            state_q <= ST_SUM;
          end
        end
        ST_SUM: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // summation of the terms, evaluated once per sample in ST_SUM
  logic signed [63:0] fixTerm, varTerm, inertia, friction, demand;
  logic breakawayOn;
  always_comb begin
    fixTerm = perUnit(64'(fixedMass_q) * 64'(gainFix_q)); // [R2]
    varTerm = perUnit(perUnit(64'(varMass_q) * 64'(gainVar_q)) * 64'(matWidth_q)); // [R3] [R5]
    inertia = perUnit(64'(accelF) * (fixTerm + varTerm)); // [R19]
    breakawayOn = (mag(snap_q.webSpeedRef) > breakaway_speed_threshold_q)
                  && (mag(snap_q.reelSpeedFb) < REEL_STILL_LIMIT); // [R16]
    friction = 64'(staticFric_q); // [R17]
    friction = friction + perUnit(64'(dynamicFric_q) * 64'(snap_q.webSpeed)); // [R1]
    if (breakawayOn) begin
      friction = friction + 64'(breakawayComp_q); // [R16]
    end
    if (ctrl_q[CTRL_FRIC_INV]) begin
      friction = -friction; // [R20]
    end
    demand = 64'(tensTerm_q) + friction + inertia; // [R18]
  end

  wtc_pct_t demand_q, mass_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      demand_q <= '0;
      mass_q <= '0;
    end else if (clkEn && state_q == ST_SUM) begin
      demand_q <= sat(demand); // [R18]
      mass_q <= sat(inertia); // [R19]
    end
  end

  // outputs register every enabled cycle so memory select acts at once
  wtc_pct_t torque;
  assign torque = memSelect ? procIn.memValue : demand_q; // [R13]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clampOut <= '0;
      totalDemandMonitor <= '0;
      massTermMonitor <= '0;
    end else if (clkEn) begin
      totalDemandMonitor <= torque; // [R13]
      massTermMonitor <= mass_q;
      clampOut <= prevailing; // [R14]
      if (ctrl_q[CTRL_TENS_EN]) begin
        if (ctrl_q[CTRL_OVERWIND]) begin
          clampOut.posLimit <= torque; // [R15]
        end else begin
          clampOut.negLimit <= sat(-64'(torque)); // [R15]
        end
      end
    end
  end

endmodule : wtc_winder_torque_compensator
`default_nettype wire

// [wtc_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module wtc_checker
  import wtc_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DOC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clkEn,
  // bus
  input wire wtc_wb_req_t wbReq,
  input wire logic [31:0] wbDatOut,
  input wire logic wbAck,
  // process side
  input wire wtc_proc_in_t procIn,
  input wire logic memSelect,
  input wire wtc_clamp_t prevailing,
  // results
  input wire wtc_clamp_t clampOut,
  input wire wtc_pct_t totalDemandMonitor,
  input wire wtc_pct_t massTermMonitor,
  input wire wtc_pct_t accelerationPort
);
  logic req;
  assign req = wbReq.cyc && wbReq.stb;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
  ack_resp_a: assert property (req && clkEn && !wbAck |=> wbAck) else $error("ack late");
  ack_idle_a: assert property (!req |=> !wbAck) else $error("ack without request");
  hi_zero_a: assert property (wbAck |-> wbDatOut[31:16] == 16'h0000)
    else $error("upper read bits set");
  mem_hold_a: assert property (
    memSelect && clkEn |=> totalDemandMonitor == $past(procIn.memValue))
    else $error("memory value not on monitor");
  prev_kept_a: assert property (clkEn |=>
    clampOut.posLimit == $past(prevailing.posLimit) ||
    clampOut.negLimit == $past(prevailing.negLimit)) else $error("both clamps replaced");
  // a steady demand lets either one cycle of clamp lag pass
  pos_clamp_a: assert property (
    clkEn && $past(clkEn) && $stable(totalDemandMonitor) && $stable(prevailing.posLimit) |->
    clampOut.posLimit == totalDemandMonitor || clampOut.posLimit == prevailing.posLimit)
    else $error("positive clamp wrong");
  neg_clamp_a: assert property (
    clkEn && $past(clkEn) && $stable(totalDemandMonitor) && $stable(prevailing.negLimit) |->
    clampOut.negLimit == -totalDemandMonitor || clampOut.negLimit == prevailing.negLimit)
    else $error("negative clamp wrong");
endmodule : wtc_checker

bind wtc_winder_torque_compensator wtc_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_wtc_checker (
  .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .wbReq(wbReq), .wbDatOut(wbDatOut),
  .wbAck(wbAck), .procIn(procIn), .memSelect(memSelect), .prevailing(prevailing),
  .clampOut(clampOut), .totalDemandMonitor(totalDemandMonitor),
  .massTermMonitor(massTermMonitor), .accelerationPort(accelerationPort));
`default_nettype wire

// [wtc_drive_model.sv]
`timescale 1ns/100ps
`default_nettype none
module wtc_drive_model
  import wtc_pkg::*;
#(
  parameter wtc_pct_t POS_PREV = 16'h3a98,
  parameter wtc_pct_t NEG_PREV = 16'hc568
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // clamps from the compensator
  input wire wtc_clamp_t clampIn,
  // drive side
  output wtc_clamp_t prevailing,
  output wtc_pct_t armCurrent
);
  assign prevailing = '{posLimit: POS_PREV, negLimit: NEG_PREV};
  // speed loop kept saturated, so current rides the clamp that was replaced
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armCurrent <= '0;
    end else if (clampIn.posLimit != POS_PREV) begin
      armCurrent <= clampIn.posLimit;
    end else begin
      armCurrent <= clampIn.negLimit;
    end
  end
endmodule : wtc_drive_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import wtc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic memSelect = 1'b0;
  wtc_wb_req_t wbReq = '0;
  wtc_proc_in_t procIn = '0;
  wtc_clamp_t prevailing, clampOut;
  logic [31:0] wbDatOut;
  logic wbAck;
  wtc_pct_t totalDemandMonitor, massTermMonitor, accelerationPort, armCurrent;
  logic [15:0] rd;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  wtc_winder_torque_compensator #(.SAMPLE_CYCLES(256)) u_wtc_winder_torque_compensator (
    .clk(clk), .rst_b(rst_b), .clkEn(clkEn), .wbReq(wbReq), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .procIn(procIn), .memSelect(memSelect), .prevailing(prevailing),
    .clampOut(clampOut), .totalDemandMonitor(totalDemandMonitor),
    .massTermMonitor(massTermMonitor), .accelerationPort(accelerationPort));
  wtc_drive_model u_wtc_drive_model (.clk(clk), .rst_b(rst_b), .clampIn(clampOut),
    .prevailing(prevailing), .armCurrent(armCurrent));

  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      wrap_up;
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // waits for ack however long the slave takes; only the watchdog ends a hang
  task wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wbReq <= '{adr: a, dat: {16'h0000, d}, sel: 4'h3, we: w, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rd = wbDatOut[15:0];
    wbReq <= '0;
  endtask : wb

  task rd_chk(input logic [7:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    chk(rd, e);
  endtask : rd_chk

  // bounded by 600 cycles, just over two samples; a miss shows up in the compare that follows
  task wait_mass(input logic [15:0] from);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (massTermMonitor === from && n < 600);
  endtask : wait_mass

  // three samples plus the divide pipeline
  task st;
    repeat (1000) @(posedge clk);
  endtask : st

  task t_regs;
    rd_chk(ADR_CTRL, 16'h0000);
    rd_chk(ADR_ACCEL_SCALER, 16'h03e8);
    rd_chk(ADR_MAT_WIDTH, 16'h2710);
    rd_chk(ADR_PULL_SCALER, 16'h0064);
    rd_chk(ADR_MIN_DIA, 16'h03e8);
    rd_chk(ADR_FILTER_TC, 16'h0000);
    wb(1'b1, 8'hfc, 16'h5555);
    rd_chk(8'hfc, 16'h0000);
    wb(1'b1, ADR_TOTAL_MON, 16'h1234);
    rd_chk(ADR_TOTAL_MON, 16'h0000);
  endtask : t_regs

  task t_tension;
    procIn.pullDemand <= 16'h1388;
    procIn.diameter <= 16'h1388;
    st;
    chk(totalDemandMonitor, 16'h09c4);
    chk(clampOut.posLimit, 16'h3a98);
    chk(clampOut.negLimit, 16'hc568);
    wb(1'b1, ADR_CTRL, 16'h0003);
    st;
    chk(clampOut.posLimit, 16'h09c4);
    chk(clampOut.negLimit, 16'hc568);
    chk(armCurrent, 16'h09c4);
    wb(1'b1, ADR_CTRL, 16'h0001);
    st;
    chk(clampOut.posLimit, 16'h3a98);
    chk(clampOut.negLimit, 16'hf63c);
    chk(armCurrent, 16'hf63c);
    wb(1'b1, ADR_PULL_SCALER, 16'h00c8);
    st;
    chk(totalDemandMonitor, 16'h04e2);
    rd_chk(ADR_TOTAL_MON, 16'h04e2);
  endtask : t_tension

  task t_friction;
    wb(1'b1, ADR_STATIC_FRIC, 16'h0064);
    wb(1'b1, ADR_DYNAMIC_FRIC, 16'h03e8);
    wb(1'b1, ADR_BREAKAWAY_COMP, 16'h012c);
    wb(1'b1, ADR_BREAKAWAY_THR, 16'h01f4);
    procIn.webSpeed <= 16'h1388;
    procIn.webSpeedRef <= 16'h03e8;
    procIn.reelSpeedFb <= 16'h00c8;
    st;
    chk(totalDemandMonitor, 16'h073a);
    procIn.reelSpeedFb <= 16'h0064;
    st;
    chk(totalDemandMonitor, 16'h0866);
    procIn.webSpeedRef <= 16'h01f4;
    st;
    chk(totalDemandMonitor, 16'h073a);
    procIn.webSpeed <= 16'h0000;
    st;
    chk(totalDemandMonitor, 16'h0546);
    wb(1'b1, ADR_CTRL, 16'h0005);
    st;
    chk(totalDemandMonitor, 16'h047e);
    wb(1'b1, ADR_STATIC_FRIC, 16'h0000);
    wb(1'b1, ADR_CTRL, 16'h0003);
    procIn.pullDemand <= 16'h0000;
  endtask : t_friction

  task t_inertia;
    wb(1'b1, ADR_ACCEL_SCALER, 16'h0000);
    // a fifth of the maximum acceleration, scaled by the caller
    wb(1'b1, ADR_ACCEL_PORT, 16'h07d0);
    wb(1'b1, ADR_FIXED_MASS, 16'h03e8);
    wb(1'b1, ADR_VAR_MASS, 16'h07d0);
    procIn.diameter <= 16'h03e8;
    st;
    chk(accelerationPort, 16'h07d0);
    chk(massTermMonitor, 16'h00c8);
    procIn.diameter <= 16'h2710;
    st;
    chk(massTermMonitor, 16'h01a4);
    wb(1'b1, ADR_MAT_WIDTH, 16'h4e20);
    st;
    chk(massTermMonitor, 16'h0334);
    chk(totalDemandMonitor, 16'h0334);
    rd_chk(ADR_MASS_MON, 16'h0334);
    // halving filter: each sample closes half of the gap to the new target
    wb(1'b1, ADR_FILTER_TC, 16'h0001);
    wb(1'b1, ADR_ACCEL_PORT, 16'h0fa0);
    wait_mass(16'h0334);
    chk(massTermMonitor, 16'h04ce);
    wait_mass(16'h04ce);
    chk(massTermMonitor, 16'h059b);
  endtask : t_inertia

  task t_calc;
    int n;
    // 2.00 stands for a 2 s full scale ramp
    wb(1'b1, ADR_ACCEL_SCALER, 16'h00c8);
    st;
    chk(accelerationPort, 16'h0000);
    procIn.lineSpeed <= 16'h0003;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (accelerationPort === 16'h0000 && n < 300);
    chk(accelerationPort, 16'h1770);
    repeat (300) @(posedge clk);
    chk(accelerationPort, 16'h0000);
  endtask : t_calc

  task t_mem;
    memSelect <= 1'b1;
    procIn.memValue <= 16'hfd44;
    repeat (3) @(posedge clk);
    chk(totalDemandMonitor, 16'hfd44);
    chk(clampOut.posLimit, 16'hfd44);
    // a low enable must freeze the outputs although the input moves
    clkEn <= 1'b0;
    procIn.memValue <= 16'h0123;
    repeat (3) @(posedge clk);
    chk(totalDemandMonitor, 16'hfd44);
    clkEn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(totalDemandMonitor, 16'h0123);
    memSelect <= 1'b0;
  endtask : t_mem

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_tension;
    t_friction;
    t_inertia;
    t_calc;
    t_mem;
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
